// >>> rtl/flash_page_self_program.sv
// Purpose: Page-wise self-programming sequencer of the program flash
// Assumes: Initiator keeps the four-cycle window and page addressing
// Notes:   Page buffer and flash array are local arrays
// What this block does
// - Flash changes whole pages, erase before write
// - Buffer load before or after erase
// - Buffer words load in any order
// - Initiator saves unchanged words before erasing
// - Erase and write use same page
// - Store accepted from any flash location
// - Code 03 plus store within four: erase
// - Erase uses page field only
// - CPU stalled during page erase
// - Software masks interrupts around the window
// - Code 01 plus store loads word
// - Buffer clears after write, reenable, reset
// - Each buffer word loaded once per fill; a second load here overwrites the word
// - EEPROM write during loading discards buffer
// - Code 05 plus store writes page
// - CPU stalled during page write
// - EEPROM write busy blocks programming
// - Erase or write lasts 3.7 to 4.5 ms
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "flash_sp_map.svh"
module flash_page_self_program #(
  parameter int PAGE_WORDS  = 32,
  parameter int PAGES       = 64,
  parameter int PROG_CYCLES = `FSP_PROG_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  spm_if.device                    cpu,
  input  wire logic                ee_write_busy,
  input  wire logic                ee_write_start,
  input  wire logic [15:0]         rd_addr,
  output var flash_sp_pkg::word_t  rd_data,
  output logic                     prog_busy
);
  import flash_sp_pkg::*;

  localparam int WB = $clog2(PAGE_WORDS);
  localparam int PB = $clog2(PAGES);
  localparam int FW = WB + PB;

  // ========================================
  // Storage
  word_t                  buf_mem   [PAGE_WORDS];
  word_t                  flash_mem [PAGES*PAGE_WORDS];
  logic [PAGE_WORDS-1:0]  valid_r;
  logic [PAGE_WORDS-1:0]  valid_nxt;
  code_t                  ctrl_r;
  code_t                  ctrl_nxt;
  logic [2:0]             win_r;
  logic [2:0]             win_nxt;
  seq_state_e             state_r;
  seq_state_e             state_nxt;
  logic [31:0]            cnt_r;
  logic [31:0]            cnt_nxt;
  logic [WB-1:0]          idx_r;
  logic [WB-1:0]          idx_nxt;
  logic [PB-1:0]          page_r;
  logic                   erase_r;
  word_t                  rd_data_r;

  // ========================================
  // Decode of control writes and store strobes
  wire          idle       = (state_r == ST_IDLE);
  wire          ctrl_take  = cpu.ctrl_wr && idle && !ee_write_busy;
  wire          reen       = ctrl_take && cpu.ctrl_wdata[`FSP_REEN_BIT];
  wire          win_open   = (win_r != 3'h0);
  // Store from any address; pc is not examined
  wire          spm_go     = cpu.spm_exec && win_open && idle;
  wire          do_load    = spm_go && ctrl_r == `FSP_CODE_LOAD;
  wire          do_erase   = spm_go && ctrl_r == `FSP_CODE_ERASE;
  wire          do_write   = spm_go && ctrl_r == `FSP_CODE_WRITE;
  wire [WB-1:0] z_word     = cpu.z_ptr[1 +: WB];
  // Only the page field is taken, other pointer bits ignored
  wire [PB-1:0] z_page     = cpu.z_ptr[1+WB +: PB];
  wire          last_word  = (idx_r == WB'(PAGE_WORDS - 1));
  wire          commit_end = (state_r == ST_COMMIT) && last_word;
  wire          ee_discard = ee_write_start && (valid_r != '0);
  wire          buf_clear  = reen || (commit_end && !erase_r) || ee_discard;
  wire [FW-1:0] commit_adr = {page_r, idx_r};
  wire [FW-1:0] rd_idx     = rd_addr[FW-1:0];

  // ========================================
  // Buffer word seen by a commit; on a write, unloaded words keep their old flash value, an erase sets every word to FFFF
  function automatic word_t commit_word(input logic erase,
                                        input logic loaded,
                                        input word_t bufw,
                                        input word_t old);
    if (erase) begin
      commit_word = `FSP_ERASED_WORD;
    end else begin
      commit_word = old & (loaded ? bufw : `FSP_ERASED_WORD);
    end
  endfunction : commit_word

  // ========================================
  // Control register and window
  always_comb begin
    ctrl_nxt = ctrl_r;
    win_nxt  = win_r;
    if (ctrl_take) begin
      ctrl_nxt = cpu.ctrl_wdata;
      win_nxt  = `FSP_SPM_WINDOW;
    end else if (spm_go || win_r == 3'h1) begin
      ctrl_nxt = `FSP_CTRL_RESET;
      win_nxt  = 3'h0;
    end else if (win_open) begin
      win_nxt  = win_r - 3'h1;
    end
  end

  // ========================================
  // Buffer valid mask; a load in the clearing cycle survives
  always_comb begin
    valid_nxt = valid_r;
    if (buf_clear) begin
      valid_nxt = '0;
    end
    if (do_load) begin
      valid_nxt[z_word] = 1'b1;
    end
  end

  // ========================================
  // Sequencer: busy for the programming time, then commit the page
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    idx_nxt   = idx_r;
    unique case (state_r)
      ST_IDLE: begin
        if (do_erase || do_write) begin
          state_nxt = ST_BUSY;
          cnt_nxt   = 32'h0000_0000;
        end
      end
      ST_BUSY: begin
        cnt_nxt = cnt_r + 32'h0000_0001;
        if (cnt_r >= 32'(PROG_CYCLES - 1)) begin
          state_nxt = ST_COMMIT;
          idx_nxt   = '0;
        end
      end
      ST_COMMIT: begin
        idx_nxt = idx_r + WB'(1);
        if (last_word) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ========================================
  // State flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= `FSP_CTRL_RESET;
      win_r   <= 3'h0;
      valid_r <= '0;
      state_r <= ST_IDLE;
      cnt_r   <= 32'h0000_0000;
      idx_r   <= '0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      win_r   <= win_nxt;
      valid_r <= valid_nxt;
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      idx_r   <= idx_nxt;
    end
  end

  // ========================================
  // Operation latch, same page for whole operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_r  <= '0;
      erase_r <= 1'b0;
    end else if (do_erase || do_write) begin
      page_r  <= z_page;
      erase_r <= do_erase;
    end
  end

  // ========================================
  // Page buffer data; the data pair fills the addressed word
  always_ff @(posedge pclk) begin
    if (do_load) begin
      buf_mem[z_word] <= cpu.data_pair;
    end
  end

  // ========================================
  // Flash array, one word per cycle during commit
  always_ff @(posedge pclk) begin
    if (state_r == ST_COMMIT) begin
      flash_mem[commit_adr] <= commit_word(erase_r, valid_r[idx_r],
                                           buf_mem[idx_r],
                                           flash_mem[commit_adr]);
    end
  end

  // ========================================
  // Read port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_r <= 16'h0000;
    end else begin
      rd_data_r <= flash_mem[rd_idx];
    end
  end

  // ========================================
  // Outputs; halt spans busy and commit
  assign cpu.cpu_halt   = !idle;
  assign cpu.ctrl_rdata = ctrl_r;
  assign prog_busy      = !idle;
  assign rd_data        = rd_data_r;

endmodule : flash_page_self_program
`default_nettype wire

// >>> common/flash_sp_map.svh
// Purpose: Offsets, codes and timing counts of the flash self-program block
// Assumes: 100 MHz system clock
// Notes:   Definitions only
`ifndef FLASH_SP_MAP_SVH
`define FLASH_SP_MAP_SVH

// ========================================
// Control codes
`define FSP_CODE_LOAD   8'h01
`define FSP_CODE_ERASE  8'h03
`define FSP_CODE_WRITE  8'h05
`define FSP_REEN_BIT    4
`define FSP_CTRL_RESET  8'h00

// ========================================
// Timing
`define FSP_SPM_WINDOW  3'h4
`define FSP_CLK_NS      10
`define FSP_PROG_MIN_NS 3700000
`define FSP_PROG_MAX_NS 4500000
`define FSP_PROG_CYCLES ((`FSP_PROG_MIN_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_ISSUE_GAP   2'h2

// ========================================
// Initiator register offsets and fields
`define FSP_OFS_CMD     12'h000
`define FSP_OFS_ZPTR    12'h004
`define FSP_OFS_DATA    12'h008
`define FSP_OFS_STATUS  12'h00C
`define FSP_ST_BUSY     0
`define FSP_ST_HALT     1
`define FSP_ST_CTRL_LSB 8
`define FSP_ERASED_WORD 16'hFFFF

`endif

// >>> common/flash_sp_pkg.sv
// Purpose: Types shared by both ends of the flash self-program link
// Assumes: Nothing
// Notes:   Constants live in flash_sp_map.svh
package flash_sp_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  code_t;
  // Gray coded along idle, busy, commit
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_BUSY   = 2'b01,
    ST_COMMIT = 2'b11
  } seq_state_e;
endpackage : flash_sp_pkg

// >>> common/spm_if.sv
// Purpose: Link between the CPU-side initiator and the flash sequencer
// Assumes: Both ends on pclk
// Notes:   No clocking block
`timescale 1ns/1ps
`default_nettype none
interface spm_if;
  import flash_sp_pkg::*;
  logic  ctrl_wr;     // One-cycle write of the control register
  code_t ctrl_wdata;
  code_t ctrl_rdata;  // Control register as the device holds it
  logic  spm_exec;    // One-cycle store-program-memory strobe
  word_t z_ptr;
  word_t data_pair;
  logic  cpu_halt;    // Level, CPU stalled while high

  modport device (input ctrl_wr, ctrl_wdata, spm_exec, z_ptr, data_pair,
                  output ctrl_rdata, cpu_halt);
  modport initiator (output ctrl_wr, ctrl_wdata, spm_exec, z_ptr,
                     data_pair, input ctrl_rdata, cpu_halt);
endinterface : spm_if
`default_nettype wire

// >>> rtl/spm_initiator.sv
// Purpose: CPU-side initiator of control writes and store strobes
// Assumes: Software orders over APB, pready always high
// Notes:   Store issued two cycles after the control write
`timescale 1ns/1ps
`default_nettype none
`include "flash_sp_map.svh"
module spm_initiator (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  spm_if.initiator                 link
);
  import flash_sp_pkg::*;

  flash_sp_pkg::word_t z_r;
  flash_sp_pkg::word_t data_r;
  code_t               code_r;
  logic                ctrl_wr_r;
  logic                spm_r;
  logic [1:0]          gap_r;
  logic                active_r;

  // ========================================
  // APB decode
  wire access  = psel && penable;
  wire hit_cmd = (paddr == `FSP_OFS_CMD);
  wire hit_z   = (paddr == `FSP_OFS_ZPTR);
  wire hit_d   = (paddr == `FSP_OFS_DATA);
  wire hit_st  = (paddr == `FSP_OFS_STATUS);
  wire mapped  = hit_cmd || hit_z || hit_d || hit_st;
  wire wr_ok   = access && pwrite && mapped;
  // Commands refused while a sequence runs or the CPU is halted
  wire start   = wr_ok && hit_cmd && !active_r && !link.cpu_halt;
  wire [31:0] status = {16'h0000, link.ctrl_rdata, 6'h00,
                        link.cpu_halt, active_r};

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = !mapped ? 32'h0000_0000 :
                   hit_z   ? {16'h0000, z_r} :
                   hit_d   ? {16'h0000, data_r} :
                   hit_cmd ? {24'h00_0000, code_r} : status;

  // ========================================
  // Pointer and data pair registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      z_r    <= 16'h0000;
      data_r <= 16'h0000;
    end else if (wr_ok && !active_r) begin
      if (hit_z) z_r <= pwdata[15:0];
      if (hit_d) data_r <= pwdata[15:0];
    end
  end

  // ========================================
  // Control write, then store inside the window, nothing between
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_r    <= `FSP_CTRL_RESET;
      ctrl_wr_r <= 1'b0;
      spm_r     <= 1'b0;
      gap_r     <= 2'h0;
      active_r  <= 1'b0;
    end else begin
      ctrl_wr_r <= start;
      spm_r     <= active_r && gap_r == 2'h1;
      if (start) begin
        code_r   <= pwdata[7:0];
        gap_r    <= `FSP_ISSUE_GAP;
        active_r <= 1'b1;
      end else if (gap_r != 2'h0) begin
        gap_r    <= gap_r - 2'h1;
      end else if (spm_r) begin
        active_r <= 1'b0;
      end
    end
  end

  assign link.ctrl_wr    = ctrl_wr_r;
  assign link.ctrl_wdata = code_r;
  assign link.spm_exec   = spm_r;
  assign link.z_ptr      = z_r;
  assign link.data_pair  = data_r;

endmodule : spm_initiator
`default_nettype wire

// >>> verif/flash_sp_link_props.sv
// Purpose: Assertions on the link between initiator and flash sequencer
// Assumes: One clock domain, reset active low
// Notes:   Instanced beside the link interface in the bench
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Link checker
module flash_sp_link_props #(
  parameter int PAGE_WORDS  = 32,
  parameter int PROG_CYCLES = 20
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 ctrl_wr,
  input wire flash_sp_pkg::code_t  ctrl_rdata,
  input wire logic                 spm_exec,
  input wire logic                 cpu_halt
);
  import flash_sp_pkg::*;
  logic [31:0] halt_cnt_r;

  // Length of the current halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) halt_cnt_r <= 32'h0000_0000;
    else if (cpu_halt) halt_cnt_r <= halt_cnt_r + 32'h0000_0001;
    else halt_cnt_r <= 32'h0000_0000;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_halt_src;
    $rose(cpu_halt) |-> $past(spm_exec);
  endproperty
  a_halt_src: assert property (p_halt_src)
    else $error("halt without a store");
  property p_erase_halt;
    spm_exec && ctrl_rdata == 8'h03 && !cpu_halt |=> cpu_halt;
  endproperty
  a_erase_halt: assert property (p_erase_halt)
    else $error("erase did not halt the core");
  property p_write_halt;
    spm_exec && ctrl_rdata == 8'h05 && !cpu_halt |=> cpu_halt;
  endproperty
  a_write_halt: assert property (p_write_halt)
    else $error("write did not halt the core");
  property p_load_no_halt;
    spm_exec && ctrl_rdata == 8'h01 && !cpu_halt |=> !cpu_halt[*2];
  endproperty
  a_load_no_halt: assert property (p_load_no_halt)
    else $error("load halted the core");
  property p_clear_on_store;
    spm_exec && ctrl_rdata != 8'h00 && !cpu_halt |=> ctrl_rdata == 8'h00;
  endproperty
  a_clear_on_store: assert property (p_clear_on_store)
    else $error("code kept after store");
  property p_halt_len;
    $fell(cpu_halt) |-> halt_cnt_r == PROG_CYCLES + PAGE_WORDS;
  endproperty
  a_halt_len: assert property (p_halt_len)
    else $error("halt length wrong");
  property p_busy_stable;
    cpu_halt |=> $stable(ctrl_rdata);
  endproperty
  a_busy_stable: assert property (p_busy_stable)
    else $error("control changed while halted");
  property p_store_window;
    ctrl_wr && !cpu_halt |-> ##[1:4] spm_exec;
  endproperty
  a_store_window: assert property (p_store_window)
    else $error("store outside window");
endmodule : flash_sp_link_props
`default_nettype wire

// >>> verif/flash_page_self_program_tb_top.sv
// Purpose: Bench joining initiator and sequencer, driven over APB
// Assumes: Short programming count for simulation
// Notes:   Word index is page times 32 plus word
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end
// ========================================
// Bench top
module flash_page_self_program_tb_top;
  import flash_sp_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        ee_write_busy, ee_write_start, prog_busy, err_seen;
  logic [15:0] rd_addr;
  word_t       rd_data;
  int          error_cnt, checks_done;

  spm_if link_if ();
  flash_page_self_program #(.PROG_CYCLES(20)) flash_page_self_program_inst (
    .pclk(pclk), .presetn(presetn), .cpu(link_if),
    .ee_write_busy(ee_write_busy), .ee_write_start(ee_write_start),
    .rd_addr(rd_addr), .rd_data(rd_data), .prog_busy(prog_busy));
  spm_initiator spm_initiator_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link_if));
  flash_sp_link_props #(.PAGE_WORDS(32), .PROG_CYCLES(20))
    flash_sp_link_props_inst (
    .pclk(pclk), .presetn(presetn), .ctrl_wr(link_if.ctrl_wr),
    .ctrl_rdata(link_if.ctrl_rdata), .spm_exec(link_if.spm_exec),
    .cpu_halt(link_if.cpu_halt));

  always #5 pclk = ~pclk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin error_cnt++; give_verdict(); end
    rdv = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Pointer, data, code, halt check, then poll until idle
  task automatic op(input code_t c, input logic [15:0] z, input word_t d,
                    input logic hb);
    int n;
    apb(12'h004, 1'b1, {16'h0000, z});
    apb(12'h008, 1'b1, {16'h0000, d});
    apb(12'h000, 1'b1, {24'h00_0000, c});
    repeat (6) @(posedge pclk);
    `CHK("halt", hb, prog_busy)
    n = 0;
    do begin apb(12'h00C, 1'b0, 32'h0000_0000); n++; end
      while (rdv[1:0] !== 2'b00 && n < 60);
    if (rdv[1:0] !== 2'b00) begin error_cnt++; give_verdict(); end
  endtask : op

  task automatic fchk(input logic [15:0] a, input word_t e);
    rd_addr <= a;
    repeat (3) @(posedge pclk);
    `CHK("flash", e, rd_data)
  endtask : fchk

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, ee_write_busy, ee_write_start} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rd_addr = 16'h0000;
    error_cnt = 0;
    checks_done = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset status and unmapped access
    apb(12'h00C, 1'b0, 32'h0000_0000);
    `CHK("status", 32'h0000_0000, rdv)
    apb(12'h010, 1'b0, 32'h0000_0000);
    `CHK("slverr", 1'b1, err_seen)
    `CHK("unmapped", 32'h0000_0000, rdv)
    $display("test registers done");
    // Fill first, out of order, junk in ignored bits
    op(8'h01, 16'h0086, 16'hBEEF, 1'b0);
    op(8'h01, 16'h0082, 16'h1234, 1'b0);
    op(8'h03, 16'hF0BE, 16'h5555, 1'b1);
    op(8'h05, 16'h0080, 16'h7777, 1'b1);
    fchk(16'd67, 16'hBEEF);
    fchk(16'd65, 16'h1234);
    fchk(16'd64, 16'hFFFF);
    $display("test fill first done");
    // Partial change: saved word reloaded, one word replaced
    op(8'h01, 16'h0086, 16'hBEEF, 1'b0);
    op(8'h01, 16'h0082, 16'h4321, 1'b0);
    op(8'h03, 16'h0080, 16'h0000, 1'b1);
    op(8'h05, 16'h0080, 16'h0000, 1'b1);
    fchk(16'd67, 16'hBEEF);
    fchk(16'd65, 16'h4321);
    $display("test partial page done");
    // Erase first, then fill; buffer empty after write
    op(8'h03, 16'h0140, 16'h0000, 1'b1);
    op(8'h01, 16'h014E, 16'hA5A5, 1'b0);
    op(8'h05, 16'h0140, 16'h0000, 1'b1);
    fchk(16'd167, 16'hA5A5);
    op(8'h03, 16'h0140, 16'h0000, 1'b1);
    op(8'h05, 16'h0140, 16'h0000, 1'b1);
    fchk(16'd167, 16'hFFFF);
    // Re-enable bit drops loaded words
    op(8'h01, 16'h0244, 16'h1234, 1'b0);
    op(8'h10, 16'h0000, 16'h0000, 1'b0);
    op(8'h03, 16'h0240, 16'h0000, 1'b1);
    op(8'h05, 16'h0240, 16'h0000, 1'b1);
    fchk(16'd290, 16'hFFFF);
    $display("test buffer clear done");
    // EEPROM start discards buffer, busy blocks erase
    op(8'h01, 16'h0308, 16'h0F0F, 1'b0);
    ee_write_start <= 1'b1;
    @(posedge pclk);
    ee_write_start <= 1'b0;
    ee_write_busy <= 1'b1;
    op(8'h03, 16'h0300, 16'h0000, 1'b0);
    ee_write_busy <= 1'b0;
    op(8'h03, 16'h0300, 16'h0000, 1'b1);
    op(8'h05, 16'h0300, 16'h0000, 1'b1);
    fchk(16'd388, 16'hFFFF);
    $display("test eeprom done");
    give_verdict();
  end
endmodule : flash_page_self_program_tb_top
`default_nettype wire
